// File: core/gpio_group_defines.vh
// Behaviour
// - Eight pins, bit n is pin n
// - Direction bit enables driver, level bit drives
// - Input synchronised, readable in either direction
// - Reset: drivers off, input buffers on
// - Direction setter sets written one bits
// - Direction clearer clears written one bits
// - Direction toggler flips written one bits
// - Level setter sets written one bits
// - Level clearer clears written one bits
// - Level toggler or input write flips level
// - Buffer off freezes synchroniser and input bit
// - Group slew limit bit for all pins
// - Pin control n at offset 0x10 plus n
// - Polarity swap inverts readback and GPIO drive, not peripheral level
// - Polarity change makes an internal edge
// - Pull-up only while pin is input
// - Buffer off setting disables input buffer
// - Alias registers act exactly like originals
// - Enabled peripheral overrides pin, others GPIO
// - Sense condition sets flag, holds request
// - Level event is pin value or zero
`ifndef GPIO_GROUP_DEFINES_VH
`define GPIO_GROUP_DEFINES_VH

// ==================================================
// Register indices (byte address is four times index)
// ==================================================
`define IDX_DIR        5'h00
`define IDX_DIR_SET    5'h01
`define IDX_DIR_CLR    5'h02
`define IDX_DIR_TGL    5'h03
`define IDX_OUT        5'h04
`define IDX_OUT_SET    5'h05
`define IDX_OUT_CLR    5'h06
`define IDX_OUT_TGL    5'h07
`define IDX_IN         5'h08
`define IDX_FLAGS      5'h09
`define IDX_GRP_CTRL   5'h0A
`define IDX_PIN_CTRL0  5'h10
`define IDX_PIN_CTRL7  5'h17
`define IDX_ALIAS_DIR  5'h18
`define IDX_ALIAS_OUT  5'h19
`define IDX_ALIAS_IN   5'h1A
`define IDX_ALIAS_FLAG 5'h1B

// ==================================================
// Bus geometry
// ==================================================
`define ADDR_W         7
`define IDX_MSB        6
`define IDX_LSB        2
`define PIN_CNT        8

// ==================================================
// Field positions
// ==================================================
`define PC_INV         7
`define PC_PULL        3
`define PC_SENSE_HI    2
`define PC_SENSE_LO    0
`define GC_SLEW        0

// ==================================================
// Sense encodings
// ==================================================
`define SENSE_NONE     3'h0
`define SENSE_BOTH     3'h1
`define SENSE_RISE     3'h2
`define SENSE_FALL     3'h3
`define SENSE_OFF      3'h4
`define SENSE_LOW      3'h5

// ==================================================
// Values
// ==================================================
`define BYTE_ZERO      8'h00
`define BYTE_ONES      8'hFF
`define WORD_ZERO      32'h00000000
`define RESP_OKAY      2'h0
`define RESP_DECERR    2'h3

`endif

// File: core/pin_sync.v
`timescale 1ns/10ps
module pin_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire ce,
    input  wire en,
    input  wire pin,
    output wire level
);

    reg meta_r;
    reg level_r;

    // Both stages hold while disabled so the level stays frozen
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r  <= 1'b0;
            level_r <= 1'b0;
        end else if (ce && en) begin
            meta_r  <= pin;
            level_r <= meta_r;
        end
    end

    assign level = level_r;

endmodule

// File: core/gpio_pin_group_control.v
`timescale 1ns/10ps
`include "gpio_group_defines.vh"
module gpio_pin_group_control (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [6:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [6:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  pad_in,
    output wire [7:0]  pad_out,
    output wire [7:0]  pad_oe_n,
    output wire [7:0]  pull_up_en,
    output wire [7:0]  in_buf_en,
    output wire        slew_limit,
    input  wire [7:0]  periph_override,
    input  wire [7:0]  periph_drive_en,
    input  wire [7:0]  periph_level,
    output wire [7:0]  pin_level_event,
    output wire        pin_irq
);

    // ==================================================
    // Address decoding
    // ==================================================
    function idx_known;
        input [4:0] idx;
        begin
            idx_known = (idx <= `IDX_GRP_CTRL) ||
                        ((idx >= `IDX_PIN_CTRL0) && (idx <= `IDX_ALIAS_FLAG));
        end
    endfunction

    // ==================================================
    // State
    // ==================================================
    reg        awready_r;
    reg        wready_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg        arready_r;
    reg        rvalid_r;
    reg [1:0]  rresp_r;
    reg [31:0] rdata_r;

    reg [7:0]  drive_enable_r;
    reg [7:0]  drive_level_r;
    reg        slew_limit_en_r;
    reg [7:0]  per_pin_control_r [0:7];
    reg [7:0]  pin_event_flags_r;
    reg [7:0]  prev_val_r;

    reg [7:0]  pad_out_r;
    reg [7:0]  pad_oe_n_r;
    reg [7:0]  pull_up_en_r;
    reg [7:0]  in_buf_en_r;
    reg        slew_limit_r;
    reg [7:0]  pin_level_event_r;
    reg        pin_irq_r;

    wire [7:0] in_raw;
    wire       wr_go;
    wire       wr_en;
    wire       rd_go;
    wire [4:0] widx;
    wire [4:0] ridx;
    wire [7:0] wb;

    reg  [7:0] buf_on;
    reg  [7:0] cur_val;
    reg  [7:0] inv_mask;
    reg  [7:0] sense_hit;
    reg  [7:0] eff_oe;
    reg  [7:0] eff_lvl;
    reg  [7:0] pull_req;
    reg  [7:0] flags_nxt;
    reg  [7:0] rd_byte;
    reg  [2:0] sense;
    integer    i;
    integer    k;

    assign widx  = s_axi_awaddr[`IDX_MSB:`IDX_LSB];
    assign ridx  = s_axi_araddr[`IDX_MSB:`IDX_LSB];
    assign wb    = s_axi_wdata[7:0];
    assign wr_go = awready_r & s_axi_awvalid & wready_r & s_axi_wvalid;
    // Only byte lane 0 carries data; a write without it changes nothing
    assign wr_en = wr_go & s_axi_wstrb[0] & idx_known(widx);
    assign rd_go = arready_r & s_axi_arvalid;

    // ==================================================
    // Input synchronisers
    // ==================================================
    genvar g;
    generate
        for (g = 0; g < `PIN_CNT; g = g + 1) begin : g_sync
            pin_sync u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .en      (buf_on[g]),
                .pin     (pad_in[g]),
                .level   (in_raw[g])
            );
        end
    endgenerate

    // ==================================================
    // Per-pin combinational logic
    // ==================================================
    always @* begin
        flags_nxt = pin_event_flags_r;
        for (i = 0; i < `PIN_CNT; i = i + 1) begin
            sense       = per_pin_control_r[i][`PC_SENSE_HI:`PC_SENSE_LO];
            inv_mask[i] = per_pin_control_r[i][`PC_INV];
            pull_req[i] = per_pin_control_r[i][`PC_PULL];
            buf_on[i]   = (sense != `SENSE_OFF);
            cur_val[i]  = in_raw[i] ^ inv_mask[i];
            case (sense)
                `SENSE_BOTH: sense_hit[i] = cur_val[i] ^ prev_val_r[i];
                `SENSE_RISE: sense_hit[i] = cur_val[i] & ~prev_val_r[i];
                `SENSE_FALL: sense_hit[i] = ~cur_val[i] & prev_val_r[i];
                `SENSE_LOW:  sense_hit[i] = ~cur_val[i];
                default:     sense_hit[i] = 1'b0;
            endcase
            eff_oe[i]   = periph_override[i] ? periph_drive_en[i] : drive_enable_r[i];
            eff_lvl[i]  = periph_override[i] ? periph_level[i] : (drive_level_r[i] ^ inv_mask[i]);
        end
        if (wr_en && ((widx == `IDX_FLAGS) || (widx == `IDX_ALIAS_FLAG))) begin
            flags_nxt = flags_nxt & ~wb;
        end
        flags_nxt = flags_nxt | sense_hit;
    end

    // ==================================================
    // Read data decode
    // ==================================================
    always @* begin
        rd_byte = `BYTE_ZERO;
        if ((ridx == `IDX_DIR) || (ridx == `IDX_ALIAS_DIR)) begin
            rd_byte = drive_enable_r;
        end else if ((ridx == `IDX_OUT) || (ridx == `IDX_ALIAS_OUT)) begin
            rd_byte = drive_level_r;
        end else if ((ridx == `IDX_IN) || (ridx == `IDX_ALIAS_IN)) begin
            rd_byte = cur_val;
        end else if ((ridx == `IDX_FLAGS) || (ridx == `IDX_ALIAS_FLAG)) begin
            rd_byte = pin_event_flags_r;
        end else if (ridx == `IDX_GRP_CTRL) begin
            rd_byte = {7'h00, slew_limit_en_r};
        end else if ((ridx >= `IDX_PIN_CTRL0) && (ridx <= `IDX_PIN_CTRL7)) begin
            rd_byte = per_pin_control_r[ridx[2:0]];
        end
    end

    // ==================================================
    // AXI4-Lite handshakes
    // ==================================================
    // Address and data are taken together; trading a cycle for simplicity
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
        end else if (ce) begin
            if (!awready_r && s_axi_awvalid && s_axi_wvalid && !bvalid_r) begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end else begin
                awready_r <= 1'b0;
                wready_r  <= 1'b0;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= idx_known(widx) ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= `RESP_OKAY;
            rdata_r   <= `WORD_ZERO;
        end else if (ce) begin
            arready_r <= !arready_r && s_axi_arvalid && !rvalid_r;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rresp_r  <= idx_known(ridx) ? `RESP_OKAY : `RESP_DECERR;
                rdata_r  <= {24'h000000, rd_byte};
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ==================================================
    // Direction register
    // ==================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            drive_enable_r <= `BYTE_ZERO;
        end else if (ce && wr_en) begin
            if ((widx == `IDX_DIR) || (widx == `IDX_ALIAS_DIR)) begin
                drive_enable_r <= wb;
            end else if (widx == `IDX_DIR_SET) begin
                drive_enable_r <= drive_enable_r | wb;
            end else if (widx == `IDX_DIR_CLR) begin
                drive_enable_r <= drive_enable_r & ~wb;
            end else if (widx == `IDX_DIR_TGL) begin
                drive_enable_r <= drive_enable_r ^ wb;
            end
        end
    end

    // ==================================================
    // Drive level register
    // ==================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            drive_level_r <= `BYTE_ZERO;
        end else if (ce && wr_en) begin
            if ((widx == `IDX_OUT) || (widx == `IDX_ALIAS_OUT)) begin
                drive_level_r <= wb;
            end else if (widx == `IDX_OUT_SET) begin
                drive_level_r <= drive_level_r | wb;
            end else if (widx == `IDX_OUT_CLR) begin
                drive_level_r <= drive_level_r & ~wb;
            end else if ((widx == `IDX_OUT_TGL) || (widx == `IDX_IN) || (widx == `IDX_ALIAS_IN)) begin
                drive_level_r <= drive_level_r ^ wb;
            end
        end
    end

    // ==================================================
    // Group and pin control
    // ==================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            slew_limit_en_r <= 1'b0;
            for (k = 0; k < `PIN_CNT; k = k + 1) begin
                per_pin_control_r[k] <= `BYTE_ZERO;
            end
        end else if (ce && wr_en) begin
            if (widx == `IDX_GRP_CTRL) begin
                slew_limit_en_r <= wb[`GC_SLEW];
            end else if ((widx >= `IDX_PIN_CTRL0) && (widx <= `IDX_PIN_CTRL7)) begin
                per_pin_control_r[widx[2:0]] <= wb;
            end
        end
    end

    // ==================================================
    // Event flags and edge history
    // ==================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_event_flags_r <= `BYTE_ZERO;
            prev_val_r        <= `BYTE_ZERO;
        end else if (ce) begin
            pin_event_flags_r <= flags_nxt;
            prev_val_r        <= cur_val;
        end
    end

    // ==================================================
    // Pad and event outputs
    // ==================================================
    // One cycle of latency on every pad control keeps outputs glitch free
    always @(posedge aclk) begin
        if (!aresetn) begin
            pad_out_r         <= `BYTE_ZERO;
            pad_oe_n_r        <= `BYTE_ONES;
            pull_up_en_r      <= `BYTE_ZERO;
            in_buf_en_r       <= `BYTE_ONES;
            slew_limit_r      <= 1'b0;
            pin_level_event_r <= `BYTE_ZERO;
            pin_irq_r         <= 1'b0;
        end else if (ce) begin
            pad_out_r         <= eff_lvl;
            pad_oe_n_r        <= ~eff_oe;
            pull_up_en_r      <= pull_req & ~eff_oe;
            in_buf_en_r       <= buf_on;
            slew_limit_r      <= slew_limit_en_r;
            pin_level_event_r <= cur_val & buf_on;
            pin_irq_r         <= |flags_nxt;
        end
    end

    assign s_axi_awready   = awready_r;
    assign s_axi_wready    = wready_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = arready_r;
    assign s_axi_rvalid    = rvalid_r;
    assign s_axi_rresp     = rresp_r;
    assign s_axi_rdata     = rdata_r;
    assign pad_out         = pad_out_r;
    assign pad_oe_n        = pad_oe_n_r;
    assign pull_up_en      = pull_up_en_r;
    assign in_buf_en       = in_buf_en_r;
    assign slew_limit      = slew_limit_r;
    assign pin_level_event = pin_level_event_r;
    assign pin_irq         = pin_irq_r;

endmodule

// File: verification/pad_model.sv
`timescale 1ns/10ps
module pad_model (
    input  wire       aclk,
    input  wire [7:0] pad_out,
    input  wire [7:0] pad_oe_n,
    input  wire [7:0] pull_up_en,
    input  wire [7:0] ext_en,
    input  wire [7:0] ext_val,
    output wire [7:0] pad_in
);
    reg [7:0] float_r = 8'h55;
    // ==========
    // Open pins
    // ==========
    // Open pins without pull-up flip every cycle so a stale level is never mistaken for a read
    always @(posedge aclk) begin
        float_r <= ~float_r;
    end
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val) |
                    (pad_oe_n & ~ext_en & (pull_up_en | float_r));
endmodule

// File: verification/gpio_pin_group_control_props.sv
`timescale 1ns/10ps
module gpio_pin_group_control_props (
    input wire        aclk,
    input wire        aresetn,
    input wire        ce,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [7:0]  pad_oe_n,
    input wire [7:0]  pull_up_en,
    input wire [7:0]  in_buf_en,
    input wire [7:0]  pin_level_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // Checks
    // ==========
    property p_rst; $rose(aresetn) |-> pad_oe_n == 8'hFF && in_buf_en == 8'hFF; endproperty
    a_rst: assert property (p_rst) else $error("drivers or buffers wrong after reset");
    property p_pull; (pull_up_en & ~pad_oe_n) == 8'h00; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on a driven pin");
    property p_evt; (pin_level_event & ~in_buf_en) == 8'h00; endproperty
    a_evt: assert property (p_evt) else $error("event from disabled buffer");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |=> s_axi_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write answer missing");
    property p_rans; s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer missing");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped");
    property p_rwid; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_rwid: assert property (p_rwid) else $error("read data wider than a byte");
endmodule

bind gpio_pin_group_control gpio_pin_group_control_props u_props (.*);

// File: verification/gpio_pin_group_control_bench.sv
`timescale 1ns/10ps
`include "gpio_group_defines.vh"
module gpio_pin_group_control_bench;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         ce = 1'b1;
    reg  [2:0]  s_axi_awprot = 3'h0;
    reg  [2:0]  s_axi_arprot = 3'h0;
    reg  [3:0]  s_axi_wstrb = 4'h1;
    reg  [6:0]  s_axi_awaddr = 7'h00;
    reg  [6:0]  s_axi_araddr = 7'h00;
    reg  [31:0] s_axi_wdata = 32'h00000000;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    reg  [7:0]  ext_en = 8'hFF;
    reg  [7:0]  ext_val = 8'h00;
    reg  [7:0]  periph_override = 8'h00;
    reg  [7:0]  periph_drive_en = 8'h00;
    reg  [7:0]  periph_level = 8'h00;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slew_limit, pin_irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  pad_in, pad_out, pad_oe_n, pull_up_en, in_buf_en, pin_level_event;
    integer     failures = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     c;
    reg  [7:0]  rise_x = 8'h26;
    reg  [7:0]  fall_x = 8'h2A;

    gpio_pin_group_control dut (.*);
    pad_model pads (.*);

    initial forever #50 aclk = ~aclk;
    // ==========
    // Tasks
    // ==========
    task end_of_test;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge aclk);
            #1;
        end
    endtask
    task setx(input [7:0] v);
        begin
            @(posedge aclk);
            ext_val <= v;
        end
    endtask
    task wr(input [4:0] idx, input [7:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_awaddr <= {idx, 2'b00};
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            do @(posedge aclk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            // Late ready leaves the response waiting a cycle, so its hold check sees traffic
            @(posedge aclk) s_axi_bready <= 1'b1;
            do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
        end
    endtask
    task rd(input [4:0] idx, input [7:0] ed, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_araddr <= {idx, 2'b00};
            s_axi_arvalid <= 1'b1;
            do @(posedge aclk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            @(posedge aclk) s_axi_rready <= 1'b1;
            do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, {24'h000000, ed});
            chk({30'h0, s_axi_rresp}, {30'h0, er});
        end
    endtask
    // Generous ceiling: the sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    // ==========
    // Sequence
    // ==========
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        chk({pad_oe_n, in_buf_en, pad_out, pull_up_en}, 32'hFFFF0000);
        chk({31'h0, slew_limit}, 32'h0);
        wr(`IDX_DIR_SET, 8'hA5, `RESP_OKAY);
        rd(`IDX_DIR, 8'hA5, `RESP_OKAY);
        wr(`IDX_DIR_CLR, 8'h81, `RESP_OKAY);
        rd(`IDX_DIR, 8'h24, `RESP_OKAY);
        wr(`IDX_DIR_TGL, 8'h0F, `RESP_OKAY);
        rd(`IDX_DIR, 8'h2B, `RESP_OKAY);
        chk({24'h0, pad_oe_n}, 32'hD4);
        wr(`IDX_OUT_SET, 8'h3C, `RESP_OKAY);
        rd(`IDX_OUT, 8'h3C, `RESP_OKAY);
        wr(`IDX_OUT_CLR, 8'h0C, `RESP_OKAY);
        rd(`IDX_OUT, 8'h30, `RESP_OKAY);
        wr(`IDX_OUT_TGL, 8'h11, `RESP_OKAY);
        wr(`IDX_IN, 8'h03, `RESP_OKAY);
        rd(`IDX_OUT, 8'h22, `RESP_OKAY);
        chk({24'h0, pad_out}, 32'h22);
        wr(`IDX_ALIAS_DIR, 8'hFF, `RESP_OKAY);
        wr(`IDX_ALIAS_OUT, 8'h5A, `RESP_OKAY);
        rd(`IDX_DIR, 8'hFF, `RESP_OKAY);
        rd(`IDX_ALIAS_IN, 8'h5A, `RESP_OKAY);
        setx(8'h96);
        wr(`IDX_DIR_CLR, 8'hFF, `RESP_OKAY);
        tick(4);
        rd(`IDX_IN, 8'h96, `RESP_OKAY);
        @(posedge aclk) ext_en <= 8'hFE;
        wr(`IDX_PIN_CTRL0, 8'h08, `RESP_OKAY);
        tick(4);
        chk({24'h0, pull_up_en}, 32'h01);
        rd(`IDX_IN, 8'h97, `RESP_OKAY);
        wr(`IDX_DIR_SET, 8'h01, `RESP_OKAY);
        tick(3);
        chk({24'h0, pull_up_en}, 32'h00);
        wr(`IDX_FLAGS, 8'hFF, `RESP_OKAY);
        wr(`IDX_PIN_CTRL0 + 5'h01, {5'h00, `SENSE_BOTH}, `RESP_OKAY);
        wr(`IDX_PIN_CTRL0 + 5'h01, 8'h81, `RESP_OKAY);
        tick(4);
        rd(`IDX_IN, 8'h94, `RESP_OKAY);
        chk({24'h0, pad_out}, 32'h58);
        chk({24'h0, pin_level_event}, 32'h94);
        rd(`IDX_ALIAS_FLAG, 8'h02, `RESP_OKAY);
        chk({31'h0, pin_irq}, 32'h1);
        wr(`IDX_FLAGS, 8'h00, `RESP_OKAY);
        rd(`IDX_FLAGS, 8'h02, `RESP_OKAY);
        wr(`IDX_FLAGS, 8'h02, `RESP_OKAY);
        rd(`IDX_FLAGS, 8'h00, `RESP_OKAY);
        chk({31'h0, pin_irq}, 32'h0);
        wr(`IDX_PIN_CTRL7, {5'h00, `SENSE_OFF}, `RESP_OKAY);
        tick(2);
        chk({24'h0, in_buf_en}, 32'h7F);
        setx(8'h92);
        for (c = 0; c < 8; c = c + 1) begin
            wr(`IDX_PIN_CTRL0 + 5'h02, c[7:0], `RESP_OKAY);
            wr(`IDX_FLAGS, 8'h04, `RESP_OKAY);
            setx(8'h96);
            tick(4);
            rd(`IDX_FLAGS, {5'h00, rise_x[c], 2'h0}, `RESP_OKAY);
            if (c == 4) begin
                rd(`IDX_IN, 8'h90, `RESP_OKAY);
                chk({in_buf_en, pin_level_event}, 32'h7B10);
            end
            wr(`IDX_FLAGS, 8'h04, `RESP_OKAY);
            setx(8'h92);
            tick(4);
            rd(`IDX_FLAGS, {5'h00, fall_x[c], 2'h0}, `RESP_OKAY);
        end
        wr(`IDX_GRP_CTRL, 8'h01, `RESP_OKAY);
        tick(2);
        chk({31'h0, slew_limit}, 32'h1);
        rd(`IDX_GRP_CTRL, 8'h01, `RESP_OKAY);
        wr(`IDX_PIN_CTRL0 + 5'h03, 8'h48, `RESP_OKAY);
        rd(5'h13, 8'h48, `RESP_OKAY);
        chk({24'h0, pull_up_en}, 32'h08);
        wr(5'h0B, 8'hFF, `RESP_DECERR);
        rd(5'h0F, 8'h00, `RESP_DECERR);
        @(posedge aclk) periph_override <= 8'h08;
        periph_drive_en <= 8'h08;
        tick(2);
        chk({pad_oe_n, pad_out, pull_up_en}, 32'hF65000);
        // Clock enable low must freeze the pad controls
        @(posedge aclk) ce <= 1'b0;
        periph_drive_en <= 8'h00;
        tick(3);
        chk({24'h0, pad_oe_n}, 32'hF6);
        @(posedge aclk) ce <= 1'b1;
        tick(2);
        chk({24'h0, pad_oe_n}, 32'hFE);
        end_of_test;
    end
endmodule
